// [dv/eis_host_model.sv]
// host model: apb master that runs one transfer per call
`timescale 1ns/1ns
`default_nettype none
module eis_host_model (
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic done,
  output logic [32:0] result
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hf;
    done = 1'b0;
    result = 33'h0;
  end
  // called just after a rising edge; holds the request until pready is sampled high or 50 wait cycles pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    result <= {pslverr, prdata};
    done <= !w;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/eis_interrupt_status_tb.sv]
// self-checking bench for the interrupt status block
`timescale 1ns/1ns
`default_nettype none
module eis_interrupt_status_tb;
  import eis_pkg::*;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, hostDone;
  logic masterIrq, powerIrq, deviceAwake, clkEn, wakeRequest;
  int nWake = 0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [32:0] hostResult;
  eis_events_t ev;
  logic [32:0] expQ[$];
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 32'h1665;
  int bits[24] = '{31, 25, 24, 23, 21, 20, 19, 17, 16, 15, 14, 13, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0};
  eis_interrupt_status i_dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .events(ev), .masterIrq(masterIrq), .powerIrq(powerIrq), .deviceAwake(deviceAwake),
    .wakeRequest(wakeRequest));
  eis_host_model i_host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .done(hostDone),
    .result(hostResult));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expQ.push_back(e);
    i_host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d);
  endtask
  // source lines in the event carrier that raise a given flag bit
  function automatic logic [41:0] evMask(input int b);
    case (b)
      31: evMask = 42'h1 << 41;
      25: evMask = 42'h3 << 39;
      24: evMask = 42'h1 << 38;
      23: evMask = 42'h1 << 37;
      21: evMask = 42'h3 << 35;
      20: evMask = 42'h1 << 34;
      19: evMask = 42'hffff << 18;
      default: evMask = (b > 12) ? 42'h1 << (b - 1) : 42'h1 << b;
    endcase
  endfunction
  // one-cycle event; timer goes 0000 -> ffff -> 0000, a single wrap
  task automatic fire(input logic [41:0] m);
    ev <= ev | m;
    @(posedge mclk);
    ev <= ev & ~m;
    @(posedge mclk);
  endtask
  // ---------------------------------------------
  // clock, watchdog, read monitor
  // ---------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
    if (wakeRequest === 1'b1) begin
      nWake++;
    end
    if (hostDone === 1'b1) begin
      chk("prdata", expQ.pop_front(), hostResult);
    end
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    ev = '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(12'h058, 33'h0);
    rd(12'h05c, 33'h0);
    rd(12'h064, {1'b0, 32'h87654321});
    $display("test reset values done");
    foreach (bits[i]) begin
      fire(evMask(bits[i]));
      rd(12'h058, 33'h1 << bits[i]);
      wr(12'h058, $random(seed) & ~(32'h1 << bits[i]));
      rd(12'h058, 33'h1 << bits[i]);
      wr(12'h058, 32'h1 << bits[i]);
      rd(12'h058, 33'h0);
    end
    fire(42'h1 << 40);
    rd(12'h058, 33'h0);
    $display("test flag set and clear done");
    ev[17] <= 1'b1;
    @(posedge mclk);
    wr(12'h058, 32'h00040000);
    rd(12'h058, 33'h00040000);
    ev[17] <= 1'b0;
    @(posedge mclk);
    rd(12'h058, 33'h0);
    wr(12'h05c, 32'hffffffff);
    rd(12'h05c, 33'h083bfefff);
    fire(evMask(6));
    chk("masterIrq", 33'h1, {32'h0, masterIrq});
    fire(evMask(17));
    chk("powerIrq", 33'h1, {32'h0, powerIrq});
    chk("deviceAwake", 33'h0, {32'h0, deviceAwake});
    wr(12'h058, 32'hffffffff);
    chk("masterIrq", 33'h0, {32'h0, masterIrq});
    wr(12'h05c, 32'h00000000);
    fire(evMask(6));
    chk("masterIrq", 33'h0, {32'h0, masterIrq});
    rd(12'h058, 33'h40);
    rd(12'h070, {1'b1, 32'h0});
    wr(12'h064, $random(seed));
    chk("deviceAwake", 33'h1, {32'h0, deviceAwake});
    chk("wakeRequest", 33'h1, 33'(nWake));
    clkEn <= 1'b0;
    fire(evMask(5));
    clkEn <= 1'b1;
    @(posedge mclk);
    rd(12'h058, 33'h40);
    $display("test mask, wake and unmapped done");
    repeat (3) @(posedge mclk);
    close_out();
  end
endmodule
`default_nettype wire

// [logic/eis_interrupt_status.sv]
// ethernet interrupt status: sticky event flags, enable mask, master line, apb slave
`timescale 1ns/1ns
`default_nettype none
module eis_interrupt_status
  import eis_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire eis_events_t events,
  output logic masterIrq,
  output logic powerIrq,
  output logic deviceAwake,
  output logic wakeRequest
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  eis_state_t st_r;
  eis_state_t st_nxt;
  logic [31:0] setVec;
  logic [31:0] flagView;
  logic access;
  logic wrFlags;
  logic wrEnable;
  logic wrByteTest;
  logic known;
  logic [31:0] wmask;

  // ---------------------------------------------
  // apb decode
  // ---------------------------------------------
  // single-cycle access phase: pready is high whenever penable is
  assign access = psel && penable && clkEn;
  assign known = (paddr == EIS_FLAGS_OFF) || (paddr == EIS_ENABLE_OFF) || (paddr == EIS_BYTE_TEST_OFF);
  assign wrFlags = access && pwrite && (paddr == EIS_FLAGS_OFF);
  assign wrEnable = access && pwrite && (paddr == EIS_ENABLE_OFF);
  assign wrByteTest = access && pwrite && (paddr == EIS_BYTE_TEST_OFF);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;
  assign prdata = st_r.rdata;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  // ---------------------------------------------
  // event detection
  // ---------------------------------------------
  always_comb begin
    setVec = 32'h00000000;
    setVec[EIS_B_SW] = events.swEnable;
    setVec[EIS_B_TXSTOP] = events.txStopReq && events.txHalted;
    setVec[EIS_B_RXSTOP] = events.rxHalted;
    setVec[EIS_B_DROPHALF] = events.dropCountMsb && !st_r.dropMsbPrev;
    setVec[EIS_B_LOADED] = events.bufferLoaded && events.notifyOnCompletion;
    setVec[EIS_B_RXDMA] = events.rxDmaDone;
    setVec[EIS_B_TIMER] = (st_r.timerPrev == EIS_TIMER_ZERO) && (events.timerCount == EIS_TIMER_WRAP);
    setVec[EIS_B_POWER] = events.powerEvent;
    setVec[EIS_B_TX_STATUS_OVERFLOW_FLAG] = events.txStatusOverflow;
    setVec[EIS_B_RWT] = events.rxOversize;
    setVec[EIS_B_RXE] = events.rxError;
    setVec[EIS_B_TXE] = events.txError;
    setVec[EIS_B_TX_DATA_UNDERRUN_FLAG] = events.txUnderrun;
    setVec[EIS_B_TX_DATA_OVERRUN_FLAG] = events.txWriteWhileFull;
    setVec[EIS_B_TX_SPACE_AVAILABLE_FLAG] = events.txSpaceAbove;
    setVec[EIS_B_TX_STATUS_FULL_FLAG] = events.txStatusFull;
    setVec[EIS_B_RX_STATUS_FULL_FLAG] = events.rxStatusFull;
    setVec[EIS_B_TX_STATUS_LEVEL_FLAG] = events.txStatusLevel;
    setVec[EIS_B_RX_DATA_LEVEL_FLAG] = events.rxDataLevel;
    setVec[EIS_B_RX_STATUS_LEVEL_FLAG] = events.rxStatusLevel;
    setVec[EIS_B_DROP] = events.frameDropped;
    setVec[2:0] = events.pinEvents;
  end

  // transceiver bit is a live mirror, cleared only at its source
  always_comb begin
    flagView = (st_r.flags & EIS_STICKY_MASK) | (EIS_LIVE_MASK & {32{events.transceiverEvent}});
  end

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (clkEn) begin
      st_nxt.dropMsbPrev = events.dropCountMsb;
      st_nxt.timerPrev = events.timerCount;
      // set wins over a same-cycle clear; mask not consulted when latching
      if (wrFlags) begin
        st_nxt.flags = ((st_r.flags & ~(pwdata & wmask)) | setVec) & EIS_STICKY_MASK;
      end else begin
        st_nxt.flags = (st_r.flags | setVec) & EIS_STICKY_MASK;
      end
      if (wrEnable) begin
        st_nxt.enable = ((st_r.enable & ~wmask) | (pwdata & wmask)) & EIS_DEFINED_MASK;
      end
      // a power event alone never wakes; only a byte-test write does
      if (wrByteTest) begin
        st_nxt.awake = 1'b1;
      end
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          EIS_FLAGS_OFF: st_nxt.rdata = flagView;
          EIS_ENABLE_OFF: st_nxt.rdata = st_r.enable;
          EIS_BYTE_TEST_OFF: st_nxt.rdata = EIS_BYTE_TEST_VAL;
          default: st_nxt.rdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r.flags <= EIS_FLAGS_RST;
      st_r.enable <= EIS_ENABLE_RST;
      st_r.dropMsbPrev <= 1'b0;
      st_r.timerPrev <= EIS_TIMER_WRAP;
      st_r.awake <= 1'b0;
      st_r.rdata <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign masterIrq = |(flagView & st_r.enable);
  // bypasses any hold-off stage downstream
  assign powerIrq = st_r.flags[EIS_B_POWER] && st_r.enable[EIS_B_POWER];
  assign deviceAwake = st_r.awake;
  assign wakeRequest = wrByteTest;

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  // named checks tie each rule to its source line; the per-bit loop covers every sticky flag

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------
  // named rules
  // ---------------------------------------------
  w1c_clear_a: assert property (
    wrFlags && pwdata[EIS_B_TXE] && pstrb[1] && !events.txError |=> !st_r.flags[EIS_B_TXE])
    else $error("flag not cleared by write one");

  zero_write_a: assert property (
    wrFlags && !pwdata[EIS_B_RXE] && st_r.flags[EIS_B_RXE] |=> st_r.flags[EIS_B_RXE])
    else $error("zero write cleared a flag");

  zero_reset_a: assert property (
    disable iff (1'b0) !rst_n |=> st_r.flags == EIS_FLAGS_RST && st_r.enable == EIS_ENABLE_RST)
    else $error("flags not zero after reset");

  rd_flags_a: assert property (
    clkEn && psel && !penable && !pwrite && paddr == EIS_FLAGS_OFF |=> prdata == $past(flagView))
    else $error("flag read does not show flags");

  ready_high_a: assert property (
    psel && penable |-> pready)
    else $error("access phase not ready");

  sw_set_a: assert property (
    clkEn && events.swEnable |=> st_r.flags[EIS_B_SW])
    else $error("software flag missed");

  tx_stop_a: assert property (
    clkEn && events.txStopReq && events.txHalted |=> st_r.flags[EIS_B_TXSTOP])
    else $error("transmit halt flag missed");

  rx_stop_a: assert property (
    clkEn && events.rxHalted |=> st_r.flags[EIS_B_RXSTOP])
    else $error("receive halt flag missed");

  drop_half_a: assert property (
    clkEn && !st_r.dropMsbPrev && events.dropCountMsb |=> st_r.flags[EIS_B_DROPHALF])
    else $error("halfway flag missed");

  loaded_set_a: assert property (
    clkEn && events.bufferLoaded && events.notifyOnCompletion |=> st_r.flags[EIS_B_LOADED])
    else $error("loaded flag missed");

  loaded_plain_a: assert property (
    !st_r.flags[EIS_B_LOADED] && !events.notifyOnCompletion |=> !st_r.flags[EIS_B_LOADED])
    else $error("loaded flag without notify");

  rx_dma_a: assert property (
    clkEn && events.rxDmaDone |=> st_r.flags[EIS_B_RXDMA])
    else $error("dma count flag missed");

  timer_wrap_a: assert property (
    clkEn && st_r.timerPrev == EIS_TIMER_ZERO && events.timerCount == EIS_TIMER_WRAP
    |=> st_r.flags[EIS_B_TIMER])
    else $error("timer wrap flag missed");

  timer_quiet_a: assert property (
    !st_r.flags[EIS_B_TIMER] && events.timerCount != EIS_TIMER_WRAP |=> !st_r.flags[EIS_B_TIMER])
    else $error("timer flag without wrap");

  xcvr_mirror_a: assert property (
    st_r.enable[EIS_B_XCVR] && events.transceiverEvent |-> masterIrq)
    else $error("transceiver event not on master line");

  xcvr_live_a: assert property (
    flagView[EIS_B_XCVR] == events.transceiverEvent)
    else $error("transceiver bit not live");

  xcvr_nostore_a: assert property (
    !st_r.flags[EIS_B_XCVR])
    else $error("transceiver bit stored");

  power_set_a: assert property (
    clkEn && events.powerEvent |=> st_r.flags[EIS_B_POWER])
    else $error("power flag missed");

  power_clear_a: assert property (
    wrFlags && pwdata[EIS_B_POWER] && pstrb[2] && !events.powerEvent |=> !st_r.flags[EIS_B_POWER])
    else $error("power flag not cleared");

  wake_only_a: assert property (
    clkEn && !st_r.awake && !wrByteTest |=> !st_r.awake)
    else $error("woke without byte test write");

  wake_write_a: assert property (
    wrByteTest |=> deviceAwake)
    else $error("byte test write did not wake");

  wake_pulse_a: assert property (
    wakeRequest |-> psel && penable && pwrite && paddr == EIS_BYTE_TEST_OFF)
    else $error("wake request without byte test write");

  power_irq_a: assert property (
    st_r.flags[EIS_B_POWER] && st_r.enable[EIS_B_POWER] |-> powerIrq && masterIrq)
    else $error("power interrupt held back");

  tx_status_overflow_flag_set_a: assert property (
    clkEn && events.txStatusOverflow |=> st_r.flags[EIS_B_TX_STATUS_OVERFLOW_FLAG])
    else $error("status overflow flag missed");

  rwt_set_a: assert property (
    clkEn && events.rxOversize |=> st_r.flags[EIS_B_RWT])
    else $error("watchdog flag missed");

  rx_err_a: assert property (
    clkEn && events.rxError |=> st_r.flags[EIS_B_RXE])
    else $error("receive error flag missed");

  tx_err_a: assert property (
    clkEn && events.txError |=> st_r.flags[EIS_B_TXE])
    else $error("transmit error flag missed");

  underrun_set_a: assert property (
    clkEn && events.txUnderrun |=> st_r.flags[EIS_B_TX_DATA_UNDERRUN_FLAG])
    else $error("underrun flag missed");

  overrun_set_a: assert property (
    clkEn && events.txWriteWhileFull |=> st_r.flags[EIS_B_TX_DATA_OVERRUN_FLAG])
    else $error("overrun flag missed");

  space_set_a: assert property (
    clkEn && events.txSpaceAbove |=> st_r.flags[EIS_B_TX_SPACE_AVAILABLE_FLAG])
    else $error("space flag missed");

  tx_full_a: assert property (
    clkEn && events.txStatusFull |=> st_r.flags[EIS_B_TX_STATUS_FULL_FLAG])
    else $error("tx status full flag missed");

  rx_full_a: assert property (
    clkEn && events.rxStatusFull |=> st_r.flags[EIS_B_RX_STATUS_FULL_FLAG])
    else $error("rx status full flag missed");

  tx_level_a: assert property (
    clkEn && events.txStatusLevel |=> st_r.flags[EIS_B_TX_STATUS_LEVEL_FLAG])
    else $error("tx status level flag missed");

  rx_data_lvl_a: assert property (
    clkEn && events.rxDataLevel |=> st_r.flags[EIS_B_RX_DATA_LEVEL_FLAG])
    else $error("rx data level flag missed");

  rx_stat_lvl_a: assert property (
    clkEn && events.rxStatusLevel |=> st_r.flags[EIS_B_RX_STATUS_LEVEL_FLAG])
    else $error("rx status level flag missed");

  set_wins_a: assert property (
    wrFlags && events.frameDropped |=> st_r.flags[EIS_B_DROP])
    else $error("event lost under clear");

  mask_free_a: assert property (
    clkEn && !st_r.enable[EIS_B_DROP] && events.frameDropped |=> st_r.flags[EIS_B_DROP])
    else $error("masked event not latched");

  master_line_a: assert property (
    (flagView & st_r.enable) == 32'h00000000 |-> !masterIrq)
    else $error("master line high with nothing enabled");

  irq_follow_a: assert property (
    (flagView & st_r.enable) != 32'h00000000 |-> masterIrq)
    else $error("master line low with enabled flag");

  reserved_zero_a: assert property (
    st_r.rdata[30:26] == 5'h00 && st_r.rdata[22] == 1'b0 && st_r.rdata[12] == 1'b0 ||
    $past(paddr) == EIS_BYTE_TEST_OFF)
    else $error("reserved bits not zero");

  enable_write_a: assert property (
    wrEnable && pstrb == 4'hf |=> st_r.enable == ($past(pwdata) & EIS_DEFINED_MASK))
    else $error("enable write wrong");

  unmapped_rd_a: assert property (
    clkEn && psel && !penable && !pwrite && !known |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");

  // ---------------------------------------------
  // pin events
  // ---------------------------------------------
  for (genvar k = 0; k < 3; k++) begin : g_pin
    pin_set_a: assert property (
      clkEn && events.pinEvents[k] |=> st_r.flags[k])
      else $error("pin flag missed");

    pin_clear_a: assert property (
      wrFlags && pwdata[k] && pstrb[0] && !events.pinEvents[k] |=> !st_r.flags[k])
      else $error("pin flag not cleared");
  end

  // ---------------------------------------------
  // per-bit flag behaviour
  // ---------------------------------------------
  // every stored bit latches, holds and clears the same way; reserved bits stay zero
  for (genvar b = 0; b < 32; b++) begin : g_bit
    if (EIS_STICKY_MASK[b]) begin : g_sticky
      bit_clear_a: assert property (
        wrFlags && pwdata[b] && pstrb[b/8] && !setVec[b] |=> !st_r.flags[b])
        else $error("write one did not clear flag");

      bit_hold_a: assert property (
        !(wrFlags && pwdata[b] && pstrb[b/8]) && st_r.flags[b] |=> st_r.flags[b])
        else $error("flag lost without a clear");

      bit_quiet_a: assert property (
        !st_r.flags[b] && !(clkEn && setVec[b]) |=> !st_r.flags[b])
        else $error("flag set without an event");
    end else if (b != EIS_B_XCVR) begin : g_reserved
      reserved_flag_a: assert property (
        !st_r.flags[b] && !flagView[b] && !st_r.enable[b])
        else $error("reserved bit not zero");
    end
  end

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  sw_cover_c: cover property (wrFlags && pwdata[EIS_B_SW] ##1 !st_r.flags[EIS_B_SW]);
  irq_cover_c: cover property (!masterIrq ##1 masterIrq);
  wake_cover_c: cover property (wrByteTest ##1 deviceAwake);
  power_cover_c: cover property (!powerIrq ##1 powerIrq);
  set_clear_cover_c: cover property (wrFlags && events.frameDropped);
endmodule
`default_nettype wire

// [logic/eis_pkg.sv]
// package for the ethernet interrupt status block: offsets, bit positions, carriers
//
// Contract
// - w1c flag word, zero writes ignored, reset zero
// - bit31 set while software enable high
// - bit25 set on stop request and halt
// - bit24 set when receiver halted
// - bit23 set on drop counter msb rise
// - bit21 set when notify buffer loaded
// - bit20 set when receive dma count done
// - bit19 set when timer wraps to ffff
// - bit18 read-only mirror of transceiver event
// - bit17 set on power event, pin-independent
// - power event never wakes; byte-test write wakes
// - hold-off never delays power event interrupt
// - bit16 set on tx status overflow
// - bit15 set on packet over 2048 bytes
// - bit14 rx error, bit13 tx error
// - bit11 set on tx data underrun
// - bit10 set on write to full fifo
// - bit9 set when tx space above threshold
// - bit8 tx status full, bit4 rx status full
// - bits7,5,3 set at fifo threshold levels
// - bit6 set on each dropped frame
// - bits2-0 latch pin events, w1c
// - flags latch regardless of enable mask
// - master line high when enabled flag active
package eis_pkg;
  // ---------------------------------------------
  // register map
  // ---------------------------------------------
  localparam logic [11:0] EIS_FLAGS_OFF = 12'h058;
  localparam logic [11:0] EIS_ENABLE_OFF = 12'h05c;
  localparam logic [11:0] EIS_BYTE_TEST_OFF = 12'h064;
  localparam logic [31:0] EIS_BYTE_TEST_VAL = 32'h87654321;
  localparam logic [31:0] EIS_FLAGS_RST = 32'h00000000;
  localparam logic [31:0] EIS_ENABLE_RST = 32'h00000000;
  // ---------------------------------------------
  // flag bit positions
  // ---------------------------------------------
  localparam int EIS_B_SW = 31;
  localparam int EIS_B_TXSTOP = 25;
  localparam int EIS_B_RXSTOP = 24;
  localparam int EIS_B_DROPHALF = 23;
  localparam int EIS_B_LOADED = 21;
  localparam int EIS_B_RXDMA = 20;
  localparam int EIS_B_TIMER = 19;
  localparam int EIS_B_XCVR = 18;
  localparam int EIS_B_POWER = 17;
  localparam int EIS_B_TX_STATUS_OVERFLOW_FLAG = 16;
  localparam int EIS_B_RWT = 15;
  localparam int EIS_B_RXE = 14;
  localparam int EIS_B_TXE = 13;
  localparam int EIS_B_TX_DATA_UNDERRUN_FLAG = 11;
  localparam int EIS_B_TX_DATA_OVERRUN_FLAG = 10;
  localparam int EIS_B_TX_SPACE_AVAILABLE_FLAG = 9;
  localparam int EIS_B_TX_STATUS_FULL_FLAG = 8;
  localparam int EIS_B_TX_STATUS_LEVEL_FLAG = 7;
  localparam int EIS_B_DROP = 6;
  localparam int EIS_B_RX_DATA_LEVEL_FLAG = 5;
  localparam int EIS_B_RX_STATUS_FULL_FLAG = 4;
  localparam int EIS_B_RX_STATUS_LEVEL_FLAG = 3;
  // bits held in a flop; bit 18 is a live mirror, reserved bits absent
  localparam logic [31:0] EIS_STICKY_MASK = 32'h83bbefff;
  localparam logic [31:0] EIS_LIVE_MASK = 32'h00040000;
  localparam logic [31:0] EIS_DEFINED_MASK = EIS_STICKY_MASK | EIS_LIVE_MASK;
  localparam logic [15:0] EIS_TIMER_WRAP = 16'hffff;
  localparam logic [15:0] EIS_TIMER_ZERO = 16'h0000;

  // ---------------------------------------------
  // carriers
  // ---------------------------------------------
  typedef struct packed {
    logic swEnable;
    logic txStopReq;
    logic txHalted;
    logic rxHalted;
    logic dropCountMsb;
    logic bufferLoaded;
    logic notifyOnCompletion;
    logic rxDmaDone;
    logic [15:0] timerCount;
    logic transceiverEvent;
    logic powerEvent;
    logic txStatusOverflow;
    logic rxOversize;
    logic rxError;
    logic txError;
    logic txUnderrun;
    logic txWriteWhileFull;
    logic txSpaceAbove;
    logic txStatusFull;
    logic txStatusLevel;
    logic frameDropped;
    logic rxDataLevel;
    logic rxStatusFull;
    logic rxStatusLevel;
    logic [2:0] pinEvents;
  } eis_events_t;

  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] enable;
    logic dropMsbPrev;
    logic [15:0] timerPrev;
    logic awake;
    logic [31:0] rdata;
  } eis_state_t;
endpackage
